//--- oet_osc_defs.vh
// constants for the oscillator enable and tc trim block
`ifndef OET_OSC_DEFS_VH
`define OET_OSC_DEFS_VH

// bus clock rate
`define OET_CLK_MHZ 25
`define OET_CLK_PERIOD_NS 40

// register indices; byte address is four times the index
`define OET_IDX_TRIM 10'h018
`define OET_IDX_REFERENCE_DIVIDER 10'h019
`define OET_IDX_OSC 10'h01a
`define OET_IDX_CFG_GUARD_FLAG 10'h01b
`define OET_IDX_OSC2 10'h01c
`define OET_IDX_CLKS 10'h01d
`define OET_IDX_FLAGS 10'h01e
`define OET_IDX_IRQ_STAT 10'h01f
`define OET_IDX_IRQ_MASK 10'h020

// osc_configuration fields
`define OET_OSC_ON_BIT 7
`define OET_OSC_RSVD_BIT 5
`define OET_OSC_RESET 8'h00
`define OET_OSC_ON_RESET 1'b0

// trim register fields
`define OET_TC_MSB 15
`define OET_TC_LSB 11
`define OET_TC_OFF_A 5'h00
`define OET_TC_OFF_B 5'h10
`define OET_TC_RESET 5'h00
`define OET_FTRIM_RESET 10'h000

// protection unlock key and guard reset value
`define OET_CFG_GUARD_FLAG_KEY 8'h26
`define OET_GUARD_RESET 1'b0

// osc_configuration_second fields
`define OET_OSC2_MODE_BIT 0
`define OET_OSC2_OSC_MONITOR_RESET_EN_BIT 1
`define OET_OSC2_RESET 2'h0

// clock select field and reset
`define OET_CLKS_PLL_CLOCK_SELECT_BIT 7
`define OET_CLKS_RESET 1'b1

// reference divider field
`define OET_REFERENCE_DIVIDER_RESET 4'h0

// flags register bits
`define OET_FLAG_STABLE_BIT 0
`define OET_FLAG_LOCK_BIT 1
`define OET_FLAG_CLAIM_BIT 2
`define OET_FLAG_GUARD_BIT 3

// interrupt status bits
`define OET_EV_STABLE 0
`define OET_EV_LOST 1
`define OET_EV_MONRST 2
`define OET_EV_W 3

// oscillator start-up: crystal edges counted before stable
`define OET_STARTUP_EDGES 12'd1024
// oscillation loss: time without an edge, rounded down to cycles
`define OET_LOSS_TIME_NS 4000
`define OET_LOSS_CYCLES ((`OET_LOSS_TIME_NS) / (`OET_CLK_PERIOD_NS))

// axi responses
`define OET_RESP_OKAY 2'b00
`define OET_RESP_SLVERR 2'b10

`endif

//--- oet_osc_monitor.v
// crystal activity monitor: start-up count, stable level, loss detection
`timescale 1ns/1ps
`default_nettype none
`include "oet_osc_defs.vh"

module oet_osc_monitor (
	input wire clk,
	input wire resetn,
	input wire enable,
	input wire osc_in,
	output reg stable,
	output reg lost_pulse,
	output reg rise_tick
);

	// loss count fits twelve bits; cut the integer on purpose
	localparam integer loss_cycles = `OET_LOSS_CYCLES;
	localparam [11:0] loss_limit = loss_cycles[11:0];

	reg prev_reg;
	reg [11:0] edge_cnt_reg;
	reg [11:0] idle_cnt_reg;
	wire rise;

	assign rise = osc_in & ~prev_reg;

	// count crystal edges while enabled; a long silence after start-up is a loss
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_reg <= 1'b0;
			edge_cnt_reg <= 12'h000;
			idle_cnt_reg <= 12'h000;
			stable <= 1'b0;
			lost_pulse <= 1'b0;
			rise_tick <= 1'b0;
		end else begin
			prev_reg <= osc_in;
			rise_tick <= enable & rise;
			lost_pulse <= 1'b0;
			if (!enable) begin
				edge_cnt_reg <= 12'h000;
				idle_cnt_reg <= 12'h000;
				stable <= 1'b0;
			end else if (rise) begin
				idle_cnt_reg <= 12'h000;
				if (edge_cnt_reg < `OET_STARTUP_EDGES)
					edge_cnt_reg <= edge_cnt_reg + 12'h001;
				else
					stable <= 1'b1;
			end else if (idle_cnt_reg >= loss_limit) begin
				// only a running oscillator can be lost; restart the count
				idle_cnt_reg <= 12'h000;
				edge_cnt_reg <= 12'h000;
				lost_pulse <= stable;
				stable <= 1'b0;
			end else begin
				idle_cnt_reg <= idle_cnt_reg + 12'h001;
			end
		end
	end

endmodule
`default_nettype wire

//--- oet_osc_ctrl.v
// oscillator enable, tc trim and clock protection registers behind axi4-lite
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "oet_osc_defs.vh"

module oet_osc_ctrl (
	input wire clk,
	input wire resetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire crystal_in_pin,
	input wire internal_rc_clk,
	input wire pll_lock_detect,
	output reg pll_reference_clk,
	output reg ref_from_crystal,
	output reg crystal_pins_claimed,
	output reg osc_monitor_reset,
	output reg osc_clk_selectable,
	output reg tc_comp_enable,
	output reg [4:0] tc_trim_code,
	output reg [9:0] freq_trim_code,
	output reg osc_full_swing,
	output reg irq
);

	// write channel holding registers
	reg aw_held_reg, w_held_reg;
	reg [11:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;

	// software state
	reg ext_osc_on_reg;
	reg osc_rsvd_reg;
	reg cfg_guard_flag_reg;
	reg pll_clock_select_reg;
	reg osc_monitor_reset_en_reg;
	reg [3:0] reference_divider_reg;
	reg osc_stable_flag_reg;
	reg pll_lock_flag_reg;
	reg [`OET_EV_W-1:0] irq_stat_reg;
	reg [`OET_EV_W-1:0] irq_mask_reg;
	reg [3:0] ref_cnt_reg;
	reg ref_div_clk_reg, stable_prev_reg;

	wire mon_stable, mon_lost, mon_rise;
	wire do_write, waddr_ok, raddr_ok, osc_wr_ok;
	wire [9:0] widx, ridx;
	wire stable_rise, monrst_event;
	wire [31:0] wr_merged_trim;
	wire [`OET_EV_W-1:0] events;

	// word index of a byte address; the two low bits are dropped, alignment is checked in mapped
	function [9:0] word_index;
		input [11:0] addr;
		begin
			word_index = addr[11:2];
		end
	endfunction

	// true when the address hits one of the mapped words
	function mapped;
		input [11:0] addr;
		reg [9:0] i;
		begin
			i = addr[11:2];
			mapped = (addr[1:0] == 2'b00) && (i >= `OET_IDX_TRIM) && (i <= `OET_IDX_IRQ_MASK);
		end
	endfunction

	// byte-lane merge of write data over the old value
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					merge[k*8 +: 8] = nw[k*8 +: 8];
		end
	endfunction

	oet_osc_monitor u_mon (
		.clk(clk),
		.resetn(resetn),
		.enable(ext_osc_on_reg & ~osc_wr_ok), // config write restarts start-up
		.osc_in(crystal_in_pin),
		.stable(mon_stable),
		.lost_pulse(mon_lost),
		.rise_tick(mon_rise)
	);

	assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	assign widx = word_index(awaddr_reg);
	assign ridx = word_index(s_axi_araddr);
	assign waddr_ok = mapped(awaddr_reg);
	assign raddr_ok = mapped(s_axi_araddr);
	assign osc_wr_ok = do_write && waddr_ok && (widx == `OET_IDX_OSC) && wstrb_reg[0]
		&& !cfg_guard_flag_reg && pll_clock_select_reg;
	assign stable_rise = mon_stable & ~stable_prev_reg;
	assign monrst_event = mon_lost & osc_monitor_reset_en_reg & ext_osc_on_reg;
	assign events = {monrst_event, mon_lost, stable_rise};
	assign wr_merged_trim = merge({16'h0000, tc_trim_code, 1'b0, freq_trim_code}, wdata_reg, wstrb_reg);

	// write address and data taken in either order, one write at a time
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `OET_RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
				s_axi_awready <= 1'b1;
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
				s_axi_wready <= 1'b1;
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= waddr_ok ? `OET_RESP_OKAY : `OET_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
			end
		end
	end

	// read channel: one read at a time, data registered with the valid
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `OET_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= raddr_ok ? `OET_RESP_OKAY : `OET_RESP_SLVERR;
				s_axi_rdata <= 32'h00000000;
				if (raddr_ok) begin
					case (ridx)
						`OET_IDX_TRIM: s_axi_rdata <= {16'h0000, tc_trim_code, 1'b0, freq_trim_code};
						`OET_IDX_REFERENCE_DIVIDER: s_axi_rdata <= {28'h0000000, reference_divider_reg};
						`OET_IDX_OSC: s_axi_rdata <= {24'h000000, ext_osc_on_reg, 1'b0, osc_rsvd_reg, 5'h00};
						`OET_IDX_CFG_GUARD_FLAG: s_axi_rdata <= {31'h00000000, cfg_guard_flag_reg};
						`OET_IDX_OSC2: s_axi_rdata <= {30'h00000000, osc_monitor_reset_en_reg, osc_full_swing};
						`OET_IDX_CLKS: s_axi_rdata <= {24'h000000, pll_clock_select_reg, 7'h00};
						`OET_IDX_FLAGS: s_axi_rdata <= {28'h0000000, cfg_guard_flag_reg, crystal_pins_claimed,
							pll_lock_flag_reg, osc_stable_flag_reg};
						`OET_IDX_IRQ_STAT: s_axi_rdata <= {29'h00000000, irq_stat_reg};
						`OET_IDX_IRQ_MASK: s_axi_rdata <= {29'h00000000, irq_mask_reg};
						default: s_axi_rdata <= 32'h00000000;
					endcase
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// protection, clock select, trims and oscillator configuration
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_guard_flag_reg <= `OET_GUARD_RESET;
			pll_clock_select_reg <= `OET_CLKS_RESET;
			ext_osc_on_reg <= `OET_OSC_ON_RESET;
			osc_rsvd_reg <= 1'b0;
			crystal_pins_claimed <= 1'b0;
			tc_trim_code <= `OET_TC_RESET;
			freq_trim_code <= `OET_FTRIM_RESET;
			reference_divider_reg <= `OET_REFERENCE_DIVIDER_RESET;
			osc_monitor_reset_en_reg <= 1'b0;
			osc_full_swing <= 1'b0;
			irq_mask_reg <= {`OET_EV_W{1'b0}};
		end else if (do_write && waddr_ok) begin
			case (widx)
				// key clears guard, anything else sets it
				`OET_IDX_CFG_GUARD_FLAG: if (wstrb_reg[0])
					cfg_guard_flag_reg <= (wdata_reg[7:0] != `OET_CFG_GUARD_FLAG_KEY);
				`OET_IDX_CLKS: if (wstrb_reg[0] && !cfg_guard_flag_reg)
					pll_clock_select_reg <= wdata_reg[`OET_CLKS_PLL_CLOCK_SELECT_BIT];
				`OET_IDX_TRIM: if (!cfg_guard_flag_reg) begin
					tc_trim_code <= wr_merged_trim[`OET_TC_MSB:`OET_TC_LSB];
					freq_trim_code <= wr_merged_trim[9:0];
				end
				`OET_IDX_REFERENCE_DIVIDER: if (wstrb_reg[0] && !cfg_guard_flag_reg)
					reference_divider_reg <= wdata_reg[3:0];
				`OET_IDX_OSC: if (osc_wr_ok) begin
					ext_osc_on_reg <= wdata_reg[`OET_OSC_ON_BIT];
					osc_rsvd_reg <= wdata_reg[`OET_OSC_RSVD_BIT];
					if (wdata_reg[`OET_OSC_ON_BIT])
						crystal_pins_claimed <= 1'b1;
				end
				// monitor and swing mode frozen while the oscillator runs
				`OET_IDX_OSC2: if (wstrb_reg[0] && !cfg_guard_flag_reg && pll_clock_select_reg
					&& !ext_osc_on_reg) begin
					osc_monitor_reset_en_reg <= wdata_reg[`OET_OSC2_OSC_MONITOR_RESET_EN_BIT];
					osc_full_swing <= wdata_reg[`OET_OSC2_MODE_BIT];
				end
				`OET_IDX_IRQ_MASK: if (wstrb_reg[0])
					irq_mask_reg <= wdata_reg[`OET_EV_W-1:0];
				default: ;
			endcase
		end
	end

	// status flags; an accepted config write clears them in that cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			osc_stable_flag_reg <= 1'b0;
			pll_lock_flag_reg <= 1'b0;
			stable_prev_reg <= 1'b0;
		end else begin
			stable_prev_reg <= mon_stable;
			if (osc_wr_ok) begin
				osc_stable_flag_reg <= 1'b0;
				pll_lock_flag_reg <= 1'b0;
			end else begin
				if (stable_rise)
					osc_stable_flag_reg <= 1'b1;
				else if (!mon_stable)
					osc_stable_flag_reg <= 1'b0;
				pll_lock_flag_reg <= pll_lock_detect;
			end
		end
	end

	// sticky events, write one to clear; a new event beats the clear
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_reg <= {`OET_EV_W{1'b0}};
			irq <= 1'b0;
		end else begin
			if (do_write && waddr_ok && (widx == `OET_IDX_IRQ_STAT) && wstrb_reg[0])
				irq_stat_reg <= (irq_stat_reg & ~wdata_reg[`OET_EV_W-1:0]) | events;
			else
				irq_stat_reg <= irq_stat_reg | events;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// crystal reference divided by divider plus one, as a half-rate toggle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ref_cnt_reg <= 4'h0;
			ref_div_clk_reg <= 1'b0;
		end else if (!ext_osc_on_reg) begin
			ref_cnt_reg <= 4'h0;
			ref_div_clk_reg <= 1'b0;
		end else if (mon_rise) begin
			if (ref_cnt_reg >= reference_divider_reg) begin
				ref_cnt_reg <= 4'h0;
				ref_div_clk_reg <= ~ref_div_clk_reg;
			end else begin
				ref_cnt_reg <= ref_cnt_reg + 4'h1;
			end
		end
	end

	// registered outputs toward the pll, reset and clock select logic
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pll_reference_clk <= 1'b0;
			ref_from_crystal <= 1'b0;
			osc_monitor_reset <= 1'b0;
			osc_clk_selectable <= 1'b0;
			tc_comp_enable <= 1'b0;
		end else begin
			ref_from_crystal <= ext_osc_on_reg;
			pll_reference_clk <= ext_osc_on_reg ? ref_div_clk_reg : internal_rc_clk;
			osc_monitor_reset <= monrst_event;
			osc_clk_selectable <= osc_stable_flag_reg;
			tc_comp_enable <= (tc_trim_code != `OET_TC_OFF_A) && (tc_trim_code != `OET_TC_OFF_B);
		end
	end

endmodule
`default_nettype wire

//--- oet_osc_assertions.sv
// concurrent checks on the oscillator control block ports
`timescale 1ns/1ps
`default_nettype none
module oet_chk (
	input wire logic clk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic internal_rc_clk,
	input wire logic pll_reference_clk,
	input wire logic ref_from_crystal,
	input wire logic crystal_pins_claimed,
	input wire logic osc_monitor_reset,
	input wire logic osc_clk_selectable,
	input wire logic tc_comp_enable,
	input wire logic [4:0] tc_trim_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// both halves of a write taken at one edge
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// trim code held long enough for a registered decode
	sequence tc_steady;
		$stable(tc_trim_code) [*2];
	endsequence
	wr_answer_a: assert property (wr_taken |=> s_axi_bvalid)
		else $error("write response missing");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	tc_off_a: assert property (tc_steady |-> tc_comp_enable == (tc_trim_code[3:0] != 4'h0))
		else $error("tc compensation decode wrong");
	claim_sticky_a: assert property (crystal_pins_claimed |=> crystal_pins_claimed)
		else $error("crystal pins released");
	claim_first_a: assert property ($rose(ref_from_crystal) |-> crystal_pins_claimed)
		else $error("crystal used without pin claim");
	// rc level shows on the reference one register later
	rc_ref_a: assert property (!ref_from_crystal [*8] ##0 $rose(pll_reference_clk)
		|-> $past(internal_rc_clk))
		else $error("reference not following rc");
	select_gate_a: assert property ($rose(osc_clk_selectable) |-> ref_from_crystal)
		else $error("selectable without oscillator");
	mon_pulse_a: assert property (osc_monitor_reset |-> ref_from_crystal ##1 !osc_monitor_reset)
		else $error("monitor reset not a single pulse");
endmodule
bind oet_osc_ctrl oet_chk chk_u (.*);
`default_nettype wire

//--- oet_crystal_out_pin_model.sv
// crystal model: oscillates only while powered and healthy
`timescale 1ns/1ps
`default_nettype none
module oet_crystal_out_pin_model #(parameter int HALF_NS = 40) (
	input wire logic run,
	output logic crystal_out_pin
);
	// a dead or unpowered crystal stands still, no free-running edges
	// edges fall on bus clock falling edges, never on the sampling edge
	initial begin
		crystal_out_pin = 1'b0;
		forever begin
			#(HALF_NS);
			crystal_out_pin = run ? !crystal_out_pin : crystal_out_pin;
		end
	end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the oscillator control block
`timescale 1ns/1ps
`default_nettype none
`include "oet_osc_defs.vh"
module tb;
	logic clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, crystal_out_pin_ok;
	logic crystal_in_pin, internal_rc_clk = 1'b0, pll_lock_detect, pll_reference_clk, ref_from_crystal;
	logic crystal_pins_claimed, osc_monitor_reset, osc_clk_selectable, tc_comp_enable, osc_full_swing;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] tc_trim_code;
	logic [9:0] freq_trim_code;
	logic [2:0] rc_div = 3'h0;
	logic [31:0] mdl [0:63];
	logic st, cl;
	int err_count, num_checks, seed, mon_count = 0, low_cnt = 0, i, n, k;
	oet_osc_ctrl dut_u (.*);
	oet_crystal_out_pin_model crystal_out_pin_u (.run(ref_from_crystal && crystal_out_pin_ok), .crystal_out_pin(crystal_in_pin));
	initial begin
		clk = 1'b0;
		forever #20 clk = !clk;
	end
	// slow rc reference and pulse counters
	always @(posedge clk) begin
		rc_div <= rc_div + 3'h1;
		internal_rc_clk <= rc_div[2];
		if (osc_monitor_reset === 1'b1) mon_count <= mon_count + 1;
		if (osc_clk_selectable === 1'b0) low_cnt <= low_cnt + 1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic tmo(input int cnt, input int lim);
		if (cnt >= lim) begin
			err_count++;
			$display("unexpected at %0t: wait ran out", $time);
			results;
		end
	endtask
	task automatic wr(input int idx, input logic [31:0] d);
		logic a, w, b, g, p;
		logic [1:0] r;
		g = mdl[`OET_IDX_CFG_GUARD_FLAG][0];
		p = mdl[`OET_IDX_CLKS][7];
		case (idx)
			`OET_IDX_CFG_GUARD_FLAG: mdl[idx] = (d[7:0] == `OET_CFG_GUARD_FLAG_KEY) ? 32'h0 : 32'h1;
			`OET_IDX_OSC: if (!g && p) begin
				mdl[idx] = d & 32'ha0;
				st = 1'b0;
				cl = cl | d[7];
			end
			`OET_IDX_CLKS: if (!g) mdl[idx] = d & 32'h80;
			`OET_IDX_TRIM: if (!g) mdl[idx] = d & 32'hfbff;
			`OET_IDX_REFERENCE_DIVIDER: if (!g) mdl[idx] = d & 32'hf;
			`OET_IDX_OSC2: if (!g && p && !mdl[`OET_IDX_OSC][7]) mdl[idx] = d & 32'h3;
			`OET_IDX_IRQ_STAT: mdl[idx] = mdl[idx] & ~d;
			`OET_IDX_IRQ_MASK: mdl[idx] = d & 32'h7;
			default: ;
		endcase
		@(posedge clk);
		s_axi_awaddr <= 12'(idx * 4);
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			a = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) break;
		end
		s_axi_bready <= 1'b0;
		tmo(k, 40);
		chk(r, `OET_RESP_OKAY);
	endtask
	task automatic rd(input int idx, input logic [31:0] exp, input logic [1:0] er);
		logic a, b;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		s_axi_araddr <= 12'(idx * 4);
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			a = s_axi_arvalid & s_axi_arready;
			b = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (a) s_axi_arvalid <= 1'b0;
			if (b) break;
		end
		s_axi_rready <= 1'b0;
		tmo(k, 40);
		chk(d, exp);
		chk(r, er);
	endtask
	task automatic wait_sel;
		for (n = 0; n < 3000 && osc_clk_selectable !== 1'b1; n++) @(posedge clk);
		tmo(n, 3000);
		st = 1'b1;
		mdl[`OET_IDX_IRQ_STAT][0] = 1'b1;
	endtask
	initial begin
		seed = 41316;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
		{resetn, pll_lock_detect, st, cl} = 4'h0;
		err_count = 0;
		num_checks = 0;
		crystal_out_pin_ok = 1'b1;
		for (i = 0; i < 64; i++) mdl[i] = 32'h0;
		mdl[`OET_IDX_CLKS] = 32'h80;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		// reset values, then an unmapped word
		for (i = 'h18; i <= 'h20; i++) if (i != 'h1e) rd(i, mdl[i], `OET_RESP_OKAY);
		rd(`OET_IDX_FLAGS, 32'h0, `OET_RESP_OKAY);
		rd('h3f, 32'h0, `OET_RESP_SLVERR);
		wr(`OET_IDX_CFG_GUARD_FLAG, 32'h11);
		wr(`OET_IDX_OSC, 32'h80);
		rd(`OET_IDX_OSC, mdl[`OET_IDX_OSC], `OET_RESP_OKAY);
		rd(`OET_IDX_FLAGS, 32'h8, `OET_RESP_OKAY);
		wr(`OET_IDX_CFG_GUARD_FLAG, 32'h26);
		wr(`OET_IDX_CLKS, 32'h0);
		wr(`OET_IDX_OSC, 32'h80);
		rd(`OET_IDX_OSC, mdl[`OET_IDX_OSC], `OET_RESP_OKAY);
		wr(`OET_IDX_CLKS, 32'h80);
		// software keeps the reserved bit at zero
		wr(`OET_IDX_OSC, 32'h5f);
		rd(`OET_IDX_OSC, mdl[`OET_IDX_OSC], `OET_RESP_OKAY);
		// every tc code with random frequency trim
		for (i = 0; i < 32; i++) begin
			wr(`OET_IDX_TRIM, {16'h0, 5'(i), 11'($random(seed))});
			rd(`OET_IDX_TRIM, mdl[`OET_IDX_TRIM], `OET_RESP_OKAY);
			chk({16'h0, tc_trim_code, 1'b0, freq_trim_code}, mdl[`OET_IDX_TRIM]);
			chk(tc_comp_enable, 32'((i % 16) != 0));
		end
		wr(`OET_IDX_IRQ_MASK, 32'h7);
		wr(`OET_IDX_OSC2, 32'h3);
		chk(osc_full_swing, 32'(mdl[`OET_IDX_OSC2][0]));
		pll_lock_detect <= 1'b1;
		wr(`OET_IDX_OSC, 32'h80);
		// look between edges: the reference flag moves on this edge
		@(negedge clk);
		chk(crystal_pins_claimed, 32'(cl));
		chk(ref_from_crystal, 32'h1);
		rd(`OET_IDX_FLAGS, 32'h6, `OET_RESP_OKAY);
		// software waits the start-up time
		wait_sel;
		rd(`OET_IDX_FLAGS, {28'h0, 1'b0, cl, 1'b1, st}, `OET_RESP_OKAY);
		chk(irq, 32'h1);
		i = low_cnt;
		wr(`OET_IDX_OSC, 32'h80);
		// selectable drops one edge after the write lands
		repeat (3) @(negedge clk);
		chk(32'(low_cnt != i), 32'h1);
		wait_sel;
		wr(`OET_IDX_IRQ_STAT, 32'h1);
		rd(`OET_IDX_IRQ_STAT, mdl[`OET_IDX_IRQ_STAT], `OET_RESP_OKAY);
		chk(irq, 32'h0);
		// crystal dies while the monitor reset is armed
		crystal_out_pin_ok <= 1'b0;
		for (n = 0; n < 400 && mon_count == 0; n++) @(posedge clk);
		tmo(n, 400);
		repeat (4) @(posedge clk);
		chk(mon_count, 32'h1);
		mdl[`OET_IDX_IRQ_STAT] = 32'h6;
		rd(`OET_IDX_IRQ_STAT, mdl[`OET_IDX_IRQ_STAT], `OET_RESP_OKAY);
		chk(irq, 32'h1);
		wr(`OET_IDX_IRQ_MASK, 32'h0);
		rd(`OET_IDX_IRQ_MASK, 32'h0, `OET_RESP_OKAY);
		chk(irq, 32'h0);
		chk(crystal_pins_claimed, 32'h1);
		// second reset frees the pins
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk(crystal_pins_claimed, 32'h0);
		results;
	end
endmodule
`default_nettype wire
